/* File: inc/halt_pkg.sv */
package halt_pkg;

    localparam int APB_AW = 8;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS = 8'h04;
    localparam logic [7:0] PRIO_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;

    localparam int CTRL_IE_BIT   = 0;
    localparam int CTRL_ISP_BIT  = 1;
    localparam int CTRL_TMSK_BIT = 2;
    localparam int CTRL_HALT_BIT = 3;

    localparam logic IE_RST   = 1'b0;
    localparam logic ISP_RST  = 1'b1;
    localparam logic TMSK_RST = 1'b1;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] PRIO_RST = 8'hFF;

    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_OUT_LSB   = 2;
    localparam int STAT_SRC_LSB   = 4;
    localparam int STAT_CAUSE_LSB = 8;

    localparam int WAIT_W = 4;
    localparam logic [WAIT_W-1:0] VEC_WAIT_CLKS  = 4'h8;
    localparam logic [WAIT_W-1:0] NEXT_WAIT_CLKS = 4'h2;
    localparam logic [WAIT_W-1:0] WAIT_ONE       = 4'h1;

    localparam logic [3:0] NMI_VECTOR = 4'h8;
    localparam int MAX_IRQ = 8;

    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAIT_VEC, ST_WAIT_NEXT} state_t;
    typedef enum logic [1:0] {OUT_HOLD, OUT_NEXT, OUT_SERVICE} outcome_t;
    typedef enum logic [1:0] {CAUSE_NONE, CAUSE_IRQ, CAUSE_NMI, CAUSE_TEST} cause_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  ad_out;
        logic        ad_oe_n;
        logic        address_strobe;
        logic        rd_n;
        logic        wr_n;
        logic        wait_out;
        logic        wait_oe_n;
    } exp_bus_t;

    typedef struct packed {
        logic [7:0] ad_in;
        logic       wait_in;
    } pin_in_t;

    localparam exp_bus_t BUS_RST = '{addr: 16'h0000, ad_out: 8'h00, ad_oe_n: 1'b1,
                                     address_strobe: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                                     wait_out: 1'b1, wait_oe_n: 1'b1};

endpackage : halt_pkg

/* File: rtl/wake_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
module wake_arbiter #(
    parameter int N_IRQ = 8
) (
    input  wire logic [N_IRQ-1:0] irq_req,   // Maskable requests
    input  wire logic [N_IRQ-1:0] irq_mask,  // Mask flags
    input  wire logic [N_IRQ-1:0] irq_prio,  // Priority flags, 1 = low
    input  wire logic             ie,        // Global enable
    input  wire logic             in_service_priority_flag,       // In-service priority flag
    input  wire logic             nmi_req,   // Non-maskable request
    input  wire logic             test_req,  // Test input
    input  wire logic             test_mask, // Test mask
    output halt_pkg::outcome_t    outcome,   // Release decision
    output halt_pkg::cause_t      cause,     // Releasing source kind
    output logic [3:0]            source     // Vector index
);
    import halt_pkg::*;

    logic [N_IRQ-1:0] live;
    logic             hi_any;
    logic             lo_any;
    logic [3:0]       hi_idx;
    logic [3:0]       lo_idx;

    always_comb begin
        live   = irq_req & ~irq_mask;
        hi_any = 1'b0;
        lo_any = 1'b0;
        hi_idx = 4'h0;
        lo_idx = 4'h0;
        // Walk downward so the lowest index wins within each priority group
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (live[i] && !irq_prio[i]) begin
                hi_any = 1'b1;
                hi_idx = 4'(i);
            end
            if (live[i] && irq_prio[i]) begin
                lo_any = 1'b1;
                lo_idx = 4'(i);
            end
        end
    end

    always_comb begin
        outcome = OUT_HOLD;
        cause   = CAUSE_NONE;
        source  = 4'h0;
        if (nmi_req) begin
            outcome = OUT_SERVICE;
            cause   = CAUSE_NMI;
            source  = NMI_VECTOR;
        end else if (hi_any) begin
            outcome = ie ? OUT_SERVICE : OUT_NEXT;
            cause   = CAUSE_IRQ;
            source  = hi_idx;
        end else if (lo_any) begin
            outcome = (ie && in_service_priority_flag) ? OUT_SERVICE : OUT_NEXT;
            cause   = CAUSE_IRQ;
            source  = lo_idx;
        end else if (test_req && !test_mask) begin
            outcome = OUT_NEXT;
            cause   = CAUSE_TEST;
        end
    end

endmodule : wake_arbiter
`default_nettype wire

/* File: rtl/halt_standby_release_control.sv */
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module halt_standby_release_control #(
    parameter int N_IRQ = 8
) (
    input  wire logic                  clk,            // 25 MHz clock
    input  wire logic                  resetn,         // Async reset, active low
    input  wire logic                  psel,           // APB select
    input  wire logic                  penable,        // APB enable
    input  wire logic                  pwrite,         // APB direction
    input  wire logic [7:0]            paddr,          // APB byte address
    input  wire logic [31:0]           pwdata,         // APB write data
    output logic                       pready,         // APB ready
    output logic [31:0]                prdata,         // APB read data
    output logic                       pslverr,        // APB error, unmapped address
    input  wire logic                  halt_instr,     // Core executed halt, pulse
    input  wire logic [N_IRQ-1:0]      irq_req,        // Maskable requests, level
    input  wire logic                  nmi_req,        // Non-maskable request, level
    input  wire logic                  test_req,       // Test input, level
    input  wire halt_pkg::exp_bus_t    core_bus,       // Bus values from the core
    input  wire halt_pkg::pin_in_t     pins_in,        // Pin input levels
    output halt_pkg::exp_bus_t         pins,           // Expansion bus pins
    output halt_pkg::pin_in_t          core_pins_in,   // Registered pin levels to core
    output logic                       core_run,       // Core clock enable
    output logic                       resume_next,    // Resume at next instruction, pulse
    output logic                       service_start,  // Vectored servicing begins, pulse
    output logic [3:0]                 service_vector, // Vector index for servicing
    output logic                       reset_branch    // Branch to reset vector, pulse
);
    import halt_pkg::*;

    // Arbiter index and status source field are 4 bits wide and index 8 is
    // NMI_VECTOR; more requests than MAX_IRQ would collide with it there
    if (N_IRQ < 1 || N_IRQ > MAX_IRQ) begin : g_bad_n_irq
        $error("N_IRQ out of range");
    end

    localparam int VEC_DLY  = int'(VEC_WAIT_CLKS);
    localparam int NEXT_DLY = int'(NEXT_WAIT_CLKS);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    state_t            state;
    state_t            next_state;
    logic [WAIT_W-1:0] wait_cnt;
    logic              ie;
    logic              in_service_priority_flag;
    logic              test_mask;
    logic [N_IRQ-1:0]  irq_mask;
    logic [N_IRQ-1:0]  irq_prio;
    outcome_t          last_outcome;
    cause_t            last_cause;
    logic [3:0]        last_source;
    logic              after_reset;
    outcome_t          arb_outcome;
    cause_t            arb_cause;
    logic [3:0]        arb_source;
    logic              wr_en;
    logic              rd_en;
    logic              mapped;
    logic              halt_cmd;
    logic [31:0]       next_prdata;

    wake_arbiter #(.N_IRQ(N_IRQ)) u_arb (
        .irq_req  (irq_req),
        .irq_mask (irq_mask),
        .irq_prio (irq_prio),
        .ie       (ie),
        .in_service_priority_flag      (in_service_priority_flag),
        .nmi_req  (nmi_req),
        .test_req (test_req),
        .test_mask(test_mask),
        .outcome  (arb_outcome),
        .cause    (arb_cause),
        .source   (arb_source)
    );

    // APB slave: one wait state, then pready for a single cycle
    assign wr_en  = psel && penable && pready && pwrite;
    assign rd_en  = psel && penable && !pready;
    assign mapped = hit(paddr, CTRL_OFS) || hit(paddr, MASK_OFS) ||
                    hit(paddr, PRIO_OFS) || hit(paddr, STAT_OFS);
    assign halt_cmd = halt_instr ||
                      (wr_en && hit(paddr, CTRL_OFS) && pwdata[CTRL_HALT_BIT]);

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit(paddr, CTRL_OFS)) begin
            next_prdata[CTRL_IE_BIT]   = ie;
            next_prdata[CTRL_ISP_BIT]  = in_service_priority_flag;
            next_prdata[CTRL_TMSK_BIT] = test_mask;
        end else if (hit(paddr, MASK_OFS)) begin
            next_prdata[N_IRQ-1:0] = irq_mask;
        end else if (hit(paddr, PRIO_OFS)) begin
            next_prdata[N_IRQ-1:0] = irq_prio;
        end else if (hit(paddr, STAT_OFS)) begin
            next_prdata[STAT_STATE_LSB +: 2] = state;
            next_prdata[STAT_OUT_LSB +: 2]   = last_outcome;
            next_prdata[STAT_SRC_LSB +: 4]   = last_source;
            next_prdata[STAT_CAUSE_LSB +: 2] = last_cause;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (rd_en && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ie        <= IE_RST;
            in_service_priority_flag       <= ISP_RST;
            test_mask <= TMSK_RST;
            irq_mask  <= MASK_RST[N_IRQ-1:0];
            irq_prio  <= PRIO_RST[N_IRQ-1:0];
        end else if (wr_en) begin
            if (hit(paddr, CTRL_OFS)) begin
                ie        <= pwdata[CTRL_IE_BIT];
                in_service_priority_flag       <= pwdata[CTRL_ISP_BIT];
                test_mask <= pwdata[CTRL_TMSK_BIT];
            end
            if (hit(paddr, MASK_OFS)) begin
                irq_mask <= pwdata[N_IRQ-1:0];
            end
            if (hit(paddr, PRIO_OFS)) begin
                irq_prio <= pwdata[N_IRQ-1:0];
            end
        end
    end

    // Halt sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (halt_cmd) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                unique case (arb_outcome)
                    OUT_SERVICE: next_state = ST_WAIT_VEC;
                    OUT_NEXT:    next_state = ST_WAIT_NEXT;
                    OUT_HOLD:    next_state = ST_HALT;
                    default:     next_state = ST_HALT;
                endcase
            end
            ST_WAIT_VEC, ST_WAIT_NEXT: begin
                if (wait_cnt == '0) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= '0;
        end else if (state == ST_HALT && next_state == ST_WAIT_VEC) begin
            wait_cnt <= VEC_WAIT_CLKS - WAIT_ONE;
        end else if (state == ST_HALT && next_state == ST_WAIT_NEXT) begin
            wait_cnt <= NEXT_WAIT_CLKS - WAIT_ONE;
        end else if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - WAIT_ONE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_outcome   <= OUT_HOLD;
            last_cause     <= CAUSE_NONE;
            last_source    <= 4'h0;
            service_vector <= 4'h0;
        end else if (state == ST_HALT && arb_outcome != OUT_HOLD) begin
            last_outcome   <= arb_outcome;
            last_cause     <= arb_cause;
            last_source    <= arb_source;
            service_vector <= arb_source;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_run      <= 1'b0;
            resume_next   <= 1'b0;
            service_start <= 1'b0;
        end else begin
            core_run      <= (next_state == ST_RUN);
            resume_next   <= (state == ST_WAIT_NEXT) && (wait_cnt == '0);
            service_start <= (state == ST_WAIT_VEC) && (wait_cnt == '0);
        end
    end

    // Reset vector branch is flagged once at the first edge after release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            after_reset  <= 1'b0;
            reset_branch <= 1'b0;
        end else begin
            after_reset  <= 1'b1;
            reset_branch <= !after_reset;
        end
    end

    // Expansion bus: pass core values while running, standby levels otherwise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins         <= BUS_RST;
            core_pins_in <= '0;
        end else begin
            core_pins_in <= pins_in;
            if (state == ST_RUN) begin
                pins <= core_bus;
            end else begin
                pins.ad_oe_n   <= 1'b1;
                pins.wait_oe_n <= 1'b1;
                pins.address_strobe      <= 1'b0;
                pins.rd_n      <= 1'b1;
                pins.wr_n      <= 1'b1;
            end
        end
    end

    a_halt_bus_levels: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT) |=> (pins.ad_oe_n && pins.wait_oe_n && !pins.address_strobe &&
                                pins.rd_n && pins.wr_n))
        else $error("bus pins not at standby levels while halted");

    a_halt_addr_held: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT) |=> $stable(pins.addr))
        else $error("address lines moved while halted");

    a_vector_wait_len: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_WAIT_VEC && $past(state) == ST_HALT) |->
            (!service_start [*8]) ##1 service_start)
        else $error("vectored release wait is not 8 clocks");

    a_next_wait_len: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_WAIT_NEXT && $past(state) == ST_HALT) |->
            ##NEXT_DLY (resume_next && core_run && !service_start))
        else $error("non-vectored release wait is not 2 clocks");

    a_irq_ack_service: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT && !nmi_req && ie && in_service_priority_flag && (irq_req & ~irq_mask) != '0) |->
            ##VEC_DLY ##1 service_start)
        else $error("enabled unmasked request did not reach servicing");

    a_irq_noack_next: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT && !nmi_req && !ie && (irq_req & ~irq_mask) != '0) |=>
            (state == ST_WAIT_NEXT))
        else $error("disabled acknowledgment did not resume at next instruction");

    a_nmi_always_wakes: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT && nmi_req) |=>
            (state == ST_WAIT_VEC) ##VEC_DLY (service_vector == NMI_VECTOR && service_start))
        else $error("non-maskable request did not vector");

    a_test_wake_hold: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT && !nmi_req && (irq_req & ~irq_mask) == '0 && test_req) |=>
            (state == (test_mask ? ST_HALT : ST_WAIT_NEXT)))
        else $error("test input handled wrongly while halted");

    a_masked_irq_hold: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT && !nmi_req && (irq_req & ~irq_mask) == '0 &&
         !(test_req && !test_mask)) |=> (state == ST_HALT && !core_run))
        else $error("halt left without an unmasked source");

    a_low_prio_isp0: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_HALT && !nmi_req && !in_service_priority_flag && (irq_req & ~irq_mask & ~irq_prio) == '0 &&
         (irq_req & ~irq_mask) != '0) |=> (state == ST_WAIT_NEXT))
        else $error("low priority request with flag 0 did not resume next");

    a_reset_branch_once: assert property (@(posedge clk) disable iff (!resetn)
        reset_branch |-> (state == ST_RUN && core_run) ##1 !reset_branch)
        else $error("reset branch pulse malformed");

endmodule : halt_standby_release_control
`default_nettype wire

/* File: verif/core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input  wire logic         clk,        // Clock
    input  wire logic         resetn,     // Reset, active low
    output logic              halt_instr, // Halt executed, pulse
    output halt_pkg::exp_bus_t core_bus,  // Bus values from the core
    output halt_pkg::pin_in_t  pins_in    // Pin levels seen by the device
);
    import halt_pkg::*;

    logic [15:0] cnt;

    initial halt_instr = 1'b0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    // Core bus keeps moving so a held address is visible
    assign core_bus = '{addr: cnt ^ 16'hA5C3, ad_out: cnt[7:0], ad_oe_n: cnt[0],
                        address_strobe: ~cnt[1], rd_n: cnt[2], wr_n: cnt[3],
                        wait_out: cnt[4], wait_oe_n: 1'b0};
    assign pins_in  = '{ad_in: ~cnt[7:0], wait_in: cnt[0]};

    task automatic halt();
        halt_instr <= 1'b1;
        @(posedge clk);
        halt_instr <= 1'b0;
    endtask : halt
endmodule : core_model
`default_nettype wire

/* File: verif/halt_standby_release_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module halt_standby_release_control_tb;
    import halt_pkg::*;

    typedef struct packed {
        logic [1:0] kind;
        logic [2:0] idx;
        logic       m;
        logic       p;
        logic       ie;
        logic       in_service_priority_flag;
        logic       tm;
        logic [1:0] res;
    } case_t;

    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, halt_instr;
    logic [7:0]  paddr, irq_req;
    logic [31:0] pwdata, prdata, rdat;
    logic        rerr, nmi_req, test_req, core_run, resume_next, service_start, reset_branch;
    logic [3:0]  service_vector;
    logic [15:0] held_addr;
    exp_bus_t    core_bus, pins, held_bus;
    pin_in_t     pins_in, core_pins_in, held_in;
    int          bad_count, check_count;
    case_t       c;
    // Kind 0 irq, 1 nmi, 2 test; result 0 hold, 1 next, 2 service
    case_t cases[9] = '{'{0,2,0,0,0,1,1,1}, '{0,2,0,0,1,1,1,2}, '{0,5,0,1,0,1,1,1},
                        '{0,5,0,1,1,0,1,1}, '{0,5,0,1,1,1,1,2}, '{0,3,1,0,1,1,1,0},
                        '{1,0,1,1,0,0,1,2}, '{2,0,1,1,0,1,0,1}, '{2,0,1,1,0,1,1,0}};

    halt_standby_release_control #(.N_IRQ(8)) halt_standby_release_control_i (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .halt_instr(halt_instr), .irq_req(irq_req),
        .nmi_req(nmi_req), .test_req(test_req), .core_bus(core_bus),
        .pins_in(pins_in), .pins(pins), .core_pins_in(core_pins_in), .core_run(core_run),
        .resume_next(resume_next), .service_start(service_start),
        .service_vector(service_vector), .reset_branch(reset_branch)
    );

    core_model core_model_i (
        .clk(clk), .resetn(resetn), .halt_instr(halt_instr),
        .core_bus(core_bus), .pins_in(pins_in)
    );

    always #20 clk = ~clk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        if (n >= 50) bad_count++;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check("reset branch", {reset_branch, core_run}, 2'b11);
        @(posedge clk);
        apb(1'b0, CTRL_OFS, 32'h0);
        check("ctrl reset", rdat, 32'h6);
    endtask : do_reset

    task automatic halt_check();
        core_model_i.halt();
        @(posedge clk);
        #1;
        held_addr = pins.addr;
        repeat (3) @(posedge clk);
        #1;
        check("standby addr", pins.addr, held_addr);
        check("standby lines", {pins.ad_oe_n, pins.wait_oe_n, pins.address_strobe, pins.rd_n,
                                pins.wr_n, core_run}, 6'b110110);
        @(posedge clk);
    endtask : halt_check

    task automatic wake(input string nm, input int exp_n, input logic svc,
                        input logic [3:0] vec);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (resume_next !== 1'b1 && service_start !== 1'b1) begin
                check({nm, " run low"}, core_run, 1'b0);
            end
        end while (resume_next !== 1'b1 && service_start !== 1'b1 && n < 20);
        check({nm, " wait"}, n, exp_n);
        check({nm, " kind"}, {service_start, resume_next}, {svc, ~svc});
        if (svc) check({nm, " vector"}, service_vector, vec);
        @(posedge clk);
    endtask : wake

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {psel, penable, pwrite, nmi_req, test_req} = 5'b00000;
        paddr = 8'h00;
        pwdata = 32'h0;
        irq_req = 8'h00;
        bad_count = 0;
        check_count = 0;
        do_reset();
        @(posedge clk);
        #1;
        held_bus = core_bus;
        held_in  = pins_in;
        @(posedge clk);
        #1;
        check("pins follow core", pins, held_bus);
        check("pin levels to core", core_pins_in, held_in);
        @(posedge clk);
        apb(1'b0, MASK_OFS, 32'h0);
        check("mask reset", rdat, 32'hFF);
        apb(1'b0, PRIO_OFS, 32'h0);
        check("prio reset", rdat, 32'hFF);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", rerr, 1'b1);
        check("unmapped data", rdat, 32'h0);
        foreach (cases[i]) begin
            c = cases[i];
            apb(1'b1, CTRL_OFS, {29'h0, c.tm, c.in_service_priority_flag, c.ie});
            apb(1'b1, MASK_OFS, c.m ? 32'hFF : ~(32'h1 << c.idx) & 32'hFF);
            apb(1'b1, PRIO_OFS, {24'h0, 8'(c.p) << c.idx});
            halt_check();
            case (c.kind)
                2'd0: irq_req[c.idx] <= 1'b1;
                2'd1: nmi_req <= 1'b1;
                default: test_req <= 1'b1;
            endcase
            if (c.res == 2'd0) begin
                repeat (12) @(posedge clk);
                #1;
                check("held", {resume_next, service_start, core_run}, 3'b000);
                @(posedge clk);
                irq_req <= 8'h00;
                test_req <= 1'b0;
                nmi_req <= 1'b1;
                wake("nmi after hold", 9, 1'b1, NMI_VECTOR);
            end else begin
                wake("release", c.res[1] ? 9 : 3, c.res[1],
                     (c.kind == 2'd1) ? NMI_VECTOR : 4'(c.idx));
            end
            if (c.kind == 2'd1) begin
                apb(1'b0, STAT_OFS, 32'h0);
                check("status nmi", rdat, 32'h288);
            end
            irq_req <= 8'h00;
            nmi_req <= 1'b0;
            test_req <= 1'b0;
            @(posedge clk);
        end
        apb(1'b1, CTRL_OFS, 32'h0000_0008);
        test_req <= 1'b1;
        wake("halt by write", 3, 1'b0, 4'h0);
        test_req <= 1'b0;
        apb(1'b0, CTRL_OFS, 32'h0);
        check("ctrl after write", rdat, 32'h0);
        halt_check();
        do_reset();
        finish_test();
    end

    initial begin
        #(40 * 6000);
        bad_count++;
        finish_test();
    end
endmodule : halt_standby_release_control_tb
`default_nettype wire
